// ===== logic/sensor_spi_pkg.sv
// constants shared by the sensor register port and its spi master
// assumes a 20 MHz core clock on both ends
package sensor_spi_pkg;
    // register indices (6-bit frame address)
    localparam logic [5:0] ADDR_SAMPLE_CONTROL = 6'h20;
    localparam logic [5:0] ADDR_IFACE_RELOAD = 6'h21;
    localparam logic [5:0] ADDR_INT_PIN_CONTROL = 6'h22;
    localparam logic [5:0] ADDR_SAMPLE_STATUS = 6'h27;
    localparam logic [5:0] ADDR_ACCEL_X = 6'h29;
    localparam logic [5:0] ADDR_ACCEL_Y = 6'h2B;
    localparam logic [5:0] ADDR_ACCEL_Z = 6'h2D;
    localparam logic [5:0] ADDR_EVENT_CONFIG = 6'h30;
    localparam logic [5:0] ADDR_EVENT_SOURCE = 6'h31;
    localparam logic [5:0] ADDR_EVENT_THRESHOLD = 6'h32;
    localparam logic [5:0] ADDR_EVENT_DURATION = 6'h33;
    // reset values
    localparam logic [7:0] RST_SAMPLE_CONTROL = 8'h07;
    localparam logic [7:0] RST_IFACE_RELOAD = 8'h00;
    localparam logic [7:0] RST_INT_PIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_EVENT_CONFIG = 8'h00;
    localparam logic [7:0] RST_EVENT_THRESHOLD = 8'h02;
    localparam logic [7:0] RST_EVENT_DURATION = 8'h00;
    // sample_control fields
    localparam int RATE_SELECT_BIT = 7;
    localparam int ACTIVE_ENABLE_BIT = 6;
    localparam int SCALE_SELECT_BIT = 5;
    localparam int SELF_TEST_POS_BIT = 4;
    localparam int SELF_TEST_NEG_BIT = 3;
    localparam int AXIS_ENABLE_LSB = 0;
    localparam int RATE_SLOW_HZ = 100;
    localparam int RATE_FAST_HZ = 400;
    // interface_reload_control fields
    localparam int WIRE_MODE_BIT = 7;
    localparam int RELOAD_BIT = 6;
    // frame layout
    localparam logic [2:0] HDR_RW_POS = 3'h0;
    localparam logic [2:0] HDR_INC_POS = 3'h1;
    localparam logic [2:0] BLOCK_LAST_POS = 3'h7;
    // calibration trim store
    localparam int TRIM_WORDS = 8;
    localparam logic [2:0] TRIM_LAST = 3'h7;
    // master timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SPC_HALF_NS = 500;
    localparam int SPC_HALF_CYCLES = (SPC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] SPC_HALF_LAST = 5'(SPC_HALF_CYCLES - 1);
    // master registers
    localparam logic [2:0] MREG_COMMAND = 3'h0;
    localparam logic [2:0] MREG_LENGTH = 3'h1;
    localparam logic [2:0] MREG_DATA0 = 3'h2;
    localparam logic [2:0] MREG_MODE = 3'h6;
    localparam logic [2:0] MREG_STATUS = 3'h7;
    localparam int MAX_BYTES = 4;

    // stand-in for the factory nonvolatile trim content; values arbitrary
    function automatic logic [7:0] nvm_trim(input logic [2:0] idx);
        nvm_trim = 8'hA5 ^ {idx, 5'h00};
    endfunction : nvm_trim
endpackage : sensor_spi_pkg

// ===== logic/sensor_spi_if.sv
// serial link between the sensor register port and its master
// resolves the shared data pin from both enables; idle lines read high
`timescale 1ns/1ps
interface sensor_spi_if;
    logic select_n;
    logic serial_port_clock;
    logic serial_in_line;
    logic serial_in_oe;
    logic shared_dev_out;
    logic shared_dev_oe;
    logic serial_out_dev;
    logic serial_out_oe;
    logic shared_data_pin;
    logic serial_out_line;

    assign shared_data_pin = shared_dev_oe ? shared_dev_out :
        (serial_in_oe ? serial_in_line : 1'b1);
    assign serial_out_line = serial_out_oe ? serial_out_dev : 1'b1;

    modport device (
        input select_n,
        input serial_port_clock,
        input shared_data_pin,
        output shared_dev_out,
        output shared_dev_oe,
        output serial_out_dev,
        output serial_out_oe
    );
    modport master (
        output select_n,
        output serial_port_clock,
        output serial_in_line,
        output serial_in_oe,
        input shared_data_pin,
        input serial_out_line
    );
endinterface : sensor_spi_if

// ===== logic/pin_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs idle high; the first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '1;
            sync_out <= '1;
        end
        else if (clk_en_in)
        begin
            meta_q <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule : pin_sync

// ===== logic/sensor_spi_device.sv
// sensor register port: spi slave end with control registers and trim reload
// assumes the master keeps the serial clock far slower than core_clk_in
// Functional notes
// - select low marks the active frame
// - master parks serial clock high between frames
// - outputs change falling, inputs sampled rising
// - 16 clocks, plus 8 per extra byte
// - bit starts at each falling clock edge
// - bit 0 direction; read drives from bit 8
// - bit 1 selects per-block address increment
// - bits 2-7 carry register index, msb first
// - read shifts register bytes out msb first
// - write stores bytes msb first into register
// - mode bit picks data-out or shared pin
// - three-wire supports same reads and increment
// - master never writes reserved or trim registers
// - trim registers restored at power up
// - rate bit picks 100 or 400 Hz
// - power bit: 0 down, 1 active
// - scale bit picks range, default 0
// - two self-test bits, default 0
// - three axis enables, default 1
// - reload bit copies trims, self-clears
// - software writes zeros to low control bits
// - select high means alternate two-wire mode; this port only ends the frame and releases both data pins
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module sensor_spi_device (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // link
    sensor_spi_if.device spi,
    // sensing core values
    input wire logic [7:0] accel_x_in,
    input wire logic [7:0] accel_y_in,
    input wire logic [7:0] accel_z_in,
    input wire logic [7:0] sample_status_in,
    input wire logic [7:0] event_source_in,
    // controls to the sensing core
    output logic rate_select_out,
    output logic active_enable_out,
    output logic scale_select_out,
    output logic self_test_positive_out,
    output logic self_test_negative_out,
    output logic [2:0] axis_enable_out,
    output logic wire_mode_select_out,
    output logic reload_busy_out,
    output logic [7:0] int_pin_control_out,
    output logic [7:0] event_config_out,
    output logic [7:0] event_threshold_out,
    output logic [7:0] event_duration_out
);
    typedef struct packed {
        logic [7:0] sample_control;
        logic [7:0] iface_reload;
        logic [7:0] int_pin_control;
        logic [7:0] event_config;
        logic [7:0] event_threshold;
        logic [7:0] event_duration;
        logic [sensor_spi_pkg::TRIM_WORDS-1:0][7:0] trim;
        logic booting;
        logic [2:0] boot_idx;
        logic clk_prev;
        logic started;
        logic data_phase;
        logic [2:0] bit_pos;
        logic read_dir;
        logic auto_inc;
        logic [5:0] addr;
        logic [7:0] write_byte;
        logic [7:0] read_shift;
        logic out_bit;
        logic shared_oe;
        logic out_line_oe;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;
    logic [2:0] pins_s;
    logic sel_n_s;
    logic clk_s;
    logic din_s;

    pin_sync #(.WIDTH(3)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .pin_in({spi.select_n, spi.serial_port_clock, spi.shared_data_pin}),
        .sync_out(pins_s)
    );
    assign sel_n_s = pins_s[2];
    assign clk_s = pins_s[1];
    assign din_s = pins_s[0];

    function automatic logic [7:0] reg_read(input dev_state_t st, input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a < 6'(sensor_spi_pkg::TRIM_WORDS))
            v = st.trim[a[2:0]];
        case (a)
            sensor_spi_pkg::ADDR_SAMPLE_CONTROL: v = st.sample_control;
            sensor_spi_pkg::ADDR_IFACE_RELOAD: v = st.iface_reload;
            sensor_spi_pkg::ADDR_INT_PIN_CONTROL: v = st.int_pin_control;
            sensor_spi_pkg::ADDR_SAMPLE_STATUS: v = sample_status_in;
            sensor_spi_pkg::ADDR_ACCEL_X: v = accel_x_in;
            sensor_spi_pkg::ADDR_ACCEL_Y: v = accel_y_in;
            sensor_spi_pkg::ADDR_ACCEL_Z: v = accel_z_in;
            sensor_spi_pkg::ADDR_EVENT_CONFIG: v = st.event_config;
            sensor_spi_pkg::ADDR_EVENT_SOURCE: v = event_source_in;
            sensor_spi_pkg::ADDR_EVENT_THRESHOLD: v = st.event_threshold;
            sensor_spi_pkg::ADDR_EVENT_DURATION: v = st.event_duration;
            default: v = v;
        endcase
        return v;
    endfunction : reg_read

    always_comb
    begin
        logic [2:0] pos_next;
        logic data_next;
        logic [7:0] rd;
        logic [7:0] wb;
        logic wire3;
        pos_next = 3'h0;
        data_next = 1'b0;
        rd = reg_read(s_q, s_q.addr);
        wb = {s_q.write_byte[6:0], din_s};
        wire3 = s_q.iface_reload[sensor_spi_pkg::WIRE_MODE_BIT];
        s_d = s_q;
        s_d.clk_prev = clk_s;
        // one trim word per cycle from the nonvolatile stand-in
        if (s_q.booting)
        begin
            s_d.trim[s_q.boot_idx] = sensor_spi_pkg::nvm_trim(s_q.boot_idx);
            s_d.boot_idx = s_q.boot_idx + 3'h1;
            if (s_q.boot_idx == sensor_spi_pkg::TRIM_LAST)
            begin
                s_d.booting = 1'b0;
                s_d.iface_reload[sensor_spi_pkg::RELOAD_BIT] = 1'b0;
            end
        end
        if (sel_n_s)
        begin
            // frame over: release both data pins
            s_d.started = 1'b0;
            s_d.data_phase = 1'b0;
            s_d.shared_oe = 1'b0;
            s_d.out_line_oe = 1'b0;
        end
        else if (s_q.clk_prev && !clk_s)
        begin
            // falling edge opens a new bit
            if (s_q.started)
            begin
                pos_next = s_q.bit_pos + 3'h1;
                data_next = s_q.data_phase || (s_q.bit_pos == sensor_spi_pkg::BLOCK_LAST_POS);
            end
            s_d.started = 1'b1;
            s_d.bit_pos = pos_next;
            s_d.data_phase = data_next;
            if (data_next && s_q.read_dir)
            begin
                s_d.read_shift = (pos_next == 3'h0) ? rd : {s_q.read_shift[6:0], 1'b0};
                s_d.out_bit = (pos_next == 3'h0) ? rd[7] : s_q.read_shift[6];
                s_d.shared_oe = wire3;
                s_d.out_line_oe = !wire3;
            end
        end
        else if (!s_q.clk_prev && clk_s && s_q.started)
        begin
            // rising edge samples the incoming bit
            if (!s_q.data_phase)
            begin
                if (s_q.bit_pos == sensor_spi_pkg::HDR_RW_POS)
                    s_d.read_dir = din_s;
                else if (s_q.bit_pos == sensor_spi_pkg::HDR_INC_POS)
                    s_d.auto_inc = din_s;
                else
                    s_d.addr = {s_q.addr[4:0], din_s};
            end
            else
            begin
                s_d.write_byte = wb;
                if (s_q.bit_pos == sensor_spi_pkg::BLOCK_LAST_POS)
                begin
                    s_d.addr = s_q.addr + {5'h00, s_q.auto_inc};
                    if (!s_q.read_dir)
                    begin
                        // read-only, reserved and unused indices drop the byte
                        case (s_q.addr)
                            sensor_spi_pkg::ADDR_SAMPLE_CONTROL: s_d.sample_control = wb;
                            sensor_spi_pkg::ADDR_IFACE_RELOAD:
                            begin
                                s_d.iface_reload = wb;
                                // a reload request beats the completion clear
                                if (wb[sensor_spi_pkg::RELOAD_BIT])
                                begin
                                    s_d.booting = 1'b1;
                                    s_d.boot_idx = 3'h0;
                                end
                            end
                            sensor_spi_pkg::ADDR_INT_PIN_CONTROL: s_d.int_pin_control = wb;
                            sensor_spi_pkg::ADDR_EVENT_CONFIG: s_d.event_config = wb;
                            sensor_spi_pkg::ADDR_EVENT_THRESHOLD: s_d.event_threshold = wb;
                            sensor_spi_pkg::ADDR_EVENT_DURATION: s_d.event_duration = wb;
                            default: s_d.addr = s_d.addr;
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= '0;
            s_q.sample_control <= sensor_spi_pkg::RST_SAMPLE_CONTROL;
            s_q.iface_reload <= sensor_spi_pkg::RST_IFACE_RELOAD;
            s_q.int_pin_control <= sensor_spi_pkg::RST_INT_PIN_CONTROL;
            s_q.event_config <= sensor_spi_pkg::RST_EVENT_CONFIG;
            s_q.event_threshold <= sensor_spi_pkg::RST_EVENT_THRESHOLD;
            s_q.event_duration <= sensor_spi_pkg::RST_EVENT_DURATION;
            s_q.booting <= 1'b1;
            s_q.clk_prev <= 1'b1;
        end
        else if (clk_en_in)
            s_q <= s_d;
    end

    assign spi.shared_dev_out = s_q.out_bit;
    assign spi.shared_dev_oe = s_q.shared_oe;
    assign spi.serial_out_dev = s_q.out_bit;
    assign spi.serial_out_oe = s_q.out_line_oe;
    assign rate_select_out = s_q.sample_control[sensor_spi_pkg::RATE_SELECT_BIT];
    assign active_enable_out = s_q.sample_control[sensor_spi_pkg::ACTIVE_ENABLE_BIT];
    assign scale_select_out = s_q.sample_control[sensor_spi_pkg::SCALE_SELECT_BIT];
    assign self_test_positive_out = s_q.sample_control[sensor_spi_pkg::SELF_TEST_POS_BIT];
    assign self_test_negative_out = s_q.sample_control[sensor_spi_pkg::SELF_TEST_NEG_BIT];
    assign axis_enable_out = s_q.sample_control[sensor_spi_pkg::AXIS_ENABLE_LSB +: 3];
    assign wire_mode_select_out = s_q.iface_reload[sensor_spi_pkg::WIRE_MODE_BIT];
    assign reload_busy_out = s_q.booting;
    assign int_pin_control_out = s_q.int_pin_control;
    assign event_config_out = s_q.event_config;
    assign event_threshold_out = s_q.event_threshold;
    assign event_duration_out = s_q.event_duration;
endmodule : sensor_spi_device

// ===== logic/sensor_spi_master.sv
// spi master end for the sensor register port, driven through small registers
// assumes software knows the device register map; serial clock made by divider
`timescale 1ns/1ps
module sensor_spi_master (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic busy_out,
    // link
    sensor_spi_if.master spi
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_END = 3'b100
    } master_state_t;

    typedef struct packed {
        master_state_t state;
        logic [4:0] cnt;
        logic [5:0] idx;
        logic [7:0] header;
        logic [1:0] len;
        logic [sensor_spi_pkg::MAX_BYTES-1:0][7:0] data;
        logic wire3;
        logic sel_n;
        logic sclk;
        logic mosi;
        logic mosi_oe;
        logic [7:0] rdata;
    } mst_state_t;

    mst_state_t s_q;
    mst_state_t s_d;
    logic [1:0] din_s;

    pin_sync #(.WIDTH(2)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .pin_in({spi.shared_data_pin, spi.serial_out_line}),
        .sync_out(din_s)
    );

    function automatic logic tx_bit(input mst_state_t st, input logic [5:0] i);
        logic [5:0] d;
        d = i - 6'd8;
        if (i < 6'd8)
            return st.header[3'h7 - i[2:0]];
        return st.data[d[4:3]][3'h7 - d[2:0]];
    endfunction : tx_bit

    always_comb
    begin
        logic [5:0] last;
        logic [5:0] d;
        logic din;
        logic busy;
        last = {1'b0, s_q.len, 3'h0} + 6'd15;
        d = s_q.idx - 6'd8;
        din = s_q.wire3 ? din_s[1] : din_s[0];
        busy = (s_q.state != ST_IDLE);
        s_d = s_q;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                sensor_spi_pkg::MREG_COMMAND: s_d.rdata = s_q.header;
                sensor_spi_pkg::MREG_LENGTH: s_d.rdata = {6'h00, s_q.len};
                sensor_spi_pkg::MREG_MODE: s_d.rdata = {7'h00, s_q.wire3};
                sensor_spi_pkg::MREG_STATUS: s_d.rdata = {7'h00, busy};
                default: s_d.rdata = s_q.data[reg_addr_in[1:0] - 2'(sensor_spi_pkg::MREG_DATA0)];
            endcase
        end
        case (s_q.state)
            ST_IDLE:
            begin
                // settings are refused while a frame runs
                if (reg_wr_in)
                begin
                    case (reg_addr_in)
                        sensor_spi_pkg::MREG_COMMAND:
                        begin
                            s_d.header = reg_wdata_in;
                            s_d.state = ST_SETUP;
                            s_d.cnt = 5'h00;
                            s_d.idx = 6'h00;
                            s_d.sel_n = 1'b0;
                            s_d.mosi_oe = 1'b1;
                        end
                        sensor_spi_pkg::MREG_LENGTH: s_d.len = reg_wdata_in[1:0];
                        sensor_spi_pkg::MREG_MODE: s_d.wire3 = reg_wdata_in[0];
                        sensor_spi_pkg::MREG_STATUS: s_d.wire3 = s_q.wire3;
                        default: s_d.data[reg_addr_in[1:0] - 2'(sensor_spi_pkg::MREG_DATA0)] =
                            reg_wdata_in;
                    endcase
                end
            end
            ST_SETUP, ST_LOW, ST_HIGH, ST_END:
            begin
                s_d.cnt = s_q.cnt + 5'h01;
                if (s_q.cnt == sensor_spi_pkg::SPC_HALF_LAST)
                begin
                    s_d.cnt = 5'h00;
                    if (s_q.state == ST_LOW)
                    begin
                        s_d.sclk = 1'b1;
                        s_d.state = ST_HIGH;
                        // sample on the rising edge
                        if (s_q.header[7] && s_q.idx >= 6'd8)
                            s_d.data[d[4:3]] = {s_q.data[d[4:3]][6:0], din};
                    end
                    else if (s_q.state == ST_END)
                    begin
                        s_d.sel_n = 1'b1;
                        s_d.mosi_oe = 1'b0;
                        s_d.state = ST_IDLE;
                    end
                    else if (s_q.state == ST_HIGH && s_q.idx == last)
                        s_d.state = ST_END;
                    else
                    begin
                        if (s_q.state == ST_HIGH)
                            s_d.idx = s_q.idx + 6'h01;
                        s_d.sclk = 1'b0;
                        s_d.mosi = tx_bit(s_q, s_d.idx);
                        // three-wire read hands the shared pin over from bit 8
                        s_d.mosi_oe = !(s_q.wire3 && s_q.header[7] && s_d.idx >= 6'd8);
                        s_d.state = ST_LOW;
                    end
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.sel_n <= 1'b1;
            s_q.sclk <= 1'b1;
            s_q.mosi <= 1'b1;
        end
        else if (clk_en_in)
            s_q <= s_d;
    end

    assign reg_rdata_out = s_q.rdata;
    assign busy_out = (s_q.state != ST_IDLE) || !s_q.sel_n;
    assign spi.select_n = s_q.sel_n;
    assign spi.serial_port_clock = s_q.sclk;
    assign spi.serial_in_line = s_q.mosi;
    assign spi.serial_in_oe = s_q.mosi_oe;
endmodule : sensor_spi_master

// ===== testbench/sensor_spi_checker.sv
// link checker: framing, clock parking and bit timing on the joined wires
// assumes one interface joins both ends, every wire seen on the core clock
`timescale 1ns/1ps
module sensor_spi_checker (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // link wires
    input wire logic select_n,
    input wire logic serial_port_clock,
    input wire logic serial_in_line,
    input wire logic shared_dev_out,
    input wire logic shared_dev_oe,
    input wire logic serial_out_dev,
    input wire logic serial_out_oe
);
    logic clk_prev_q;
    logic [3:0] clk_age_q;
    logic [3:0] fall_age_q;
    logic [5:0] rise_cnt_q;
    logic dev_oe;
    assign dev_oe = shared_dev_oe | serial_out_oe;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ages saturate so a long idle gap never wraps into a short period
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            clk_prev_q <= 1'b1;
            clk_age_q <= 4'hF;
            fall_age_q <= 4'hF;
            rise_cnt_q <= 6'h00;
        end
        else
        begin
            clk_prev_q <= serial_port_clock;
            clk_age_q <= (serial_port_clock != clk_prev_q) ? 4'h0
                : clk_age_q + 4'(clk_age_q != 4'hF);
            fall_age_q <= (clk_prev_q && !serial_port_clock) ? 4'h0
                : fall_age_q + 4'(fall_age_q != 4'hF);
            rise_cnt_q <= select_n ? 6'h00 : rise_cnt_q + 6'(!clk_prev_q && serial_port_clock);
        end
    end
    AST_CLK_PARK: assert property (select_n |-> serial_port_clock)
        else $error("serial clock not parked high");
    AST_SEL_GAP: assert property ($rose(select_n) |-> select_n[*3])
        else $error("select high gap too short");
    AST_DEV_QUIET: assert property (select_n[*4] |-> !dev_oe)
        else $error("device drives outside a frame");
    AST_ONE_PIN: assert property (!(shared_dev_oe && serial_out_oe))
        else $error("device drives both data pins");
    AST_OE_START: assert property ($rose(dev_oe) |-> fall_age_q <= 4'h5)
        else $error("read drive not started at a falling edge");
    AST_OUT_EDGE: assert property (serial_out_oe && $changed(serial_out_dev)
        |-> fall_age_q <= 4'h5)
        else $error("data out changed away from falling edge");
    AST_SHARED_EDGE: assert property (shared_dev_oe && $changed(shared_dev_out)
        |-> fall_age_q <= 4'h5)
        else $error("shared pin changed away from falling edge");
    AST_IN_HOLD: assert property (!select_n && !clk_prev_q && serial_port_clock
        |-> $stable(serial_in_line))
        else $error("master data changed at rising edge");
    AST_HALF: assert property (serial_port_clock != clk_prev_q |-> clk_age_q >= 4'h9)
        else $error("serial clock half period short");
    AST_FRAME_LEN: assert property ($rose(select_n)
        |-> rise_cnt_q >= 6'h10 && rise_cnt_q[2:0] == 3'h0)
        else $error("frame clock count not 16 plus blocks of 8");
endmodule : sensor_spi_checker

// ===== testbench/tb_sensor_spi_register_port.sv
// self-checking bench: both ends joined, driven through the master register port
// assumes master map: 0 command, 1 length, 2..5 data, 6 mode
`timescale 1ns/1ps
module tb_sensor_spi_register_port;
    logic core_clk_in;
    logic rst_n_in;
    logic [2:0] ra;
    logic [7:0] wd;
    logic wr_s, rd_s, ce;
    logic [7:0] rdat;
    logic busy, rld, saw, wm;
    logic [7:0] c1, ipc, cfg, ths, dur;
    int bad_count;
    int cmp_count;
    sensor_spi_if i_sensor_spi_if ();
    sensor_spi_device i_sensor_spi_device (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(ce), .spi(i_sensor_spi_if), .accel_x_in(8'h5A), .accel_y_in(8'h66),
        .accel_z_in(8'h99), .sample_status_in(8'h3C), .event_source_in(8'h41),
        .rate_select_out(c1[7]), .active_enable_out(c1[6]), .scale_select_out(c1[5]),
        .self_test_positive_out(c1[4]), .self_test_negative_out(c1[3]),
        .axis_enable_out(c1[2:0]), .wire_mode_select_out(wm), .reload_busy_out(rld),
        .int_pin_control_out(ipc), .event_config_out(cfg), .event_threshold_out(ths),
        .event_duration_out(dur));
    sensor_spi_master i_sensor_spi_master (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(ce), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdat), .busy_out(busy), .spi(i_sensor_spi_if));
    sensor_spi_checker i_sensor_spi_checker (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .select_n(i_sensor_spi_if.select_n), .serial_port_clock(i_sensor_spi_if.serial_port_clock),
        .serial_in_line(i_sensor_spi_if.serial_in_line),
        .shared_dev_out(i_sensor_spi_if.shared_dev_out),
        .shared_dev_oe(i_sensor_spi_if.shared_dev_oe),
        .serial_out_dev(i_sensor_spi_if.serial_out_dev),
        .serial_out_oe(i_sensor_spi_if.serial_out_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        ra <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge core_clk_in);
        wr_s <= 1'b0;
    endtask : wr
    // poll covers the reload copy too, which may outlast the frame
    task automatic wait_idle();
        repeat (3) @(posedge core_clk_in);
        for (int i = 0; i < 3000 && (busy !== 1'b0 || rld !== 1'b0); i++)
        begin
            @(posedge core_clk_in);
            if (rld === 1'b1)
                saw = 1'b1;
        end
        chk({6'h00, busy, rld}, 8'h00);
        repeat (4) @(posedge core_clk_in);
    endtask : wait_idle
    // cmd is {read, increment, index}; dat holds byte 0 in its top bits
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] dat);
        for (int i = 0; i < n; i++)
            if (!cmd[7])
                wr(3'(2 + i), dat[31 - 8 * i -: 8]);
        wr(3'h1, 8'(n - 1));
        wr(3'h0, cmd);
        wait_idle();
        for (int i = 0; i < n && cmd[7]; i++)
        begin
            @(posedge core_clk_in);
            ra <= 3'(2 + i);
            rd_s <= 1'b1;
            @(posedge core_clk_in);
            rd_s <= 1'b0;
            #1 chk(rdat, dat[31 - 8 * i -: 8]);
        end
    endtask : xfer
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    initial
    begin
        #2000000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        {ra, wd, wr_s, rd_s, saw, rst_n_in} = '0;
        ce = 1'b1;
        bad_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        wait_idle();
        chk({7'h00, saw}, 8'h01);
        xfer(8'hC0, 2, 32'hA585_0000);
        xfer(8'hE0, 3, 32'h0700_0000);
        xfer(8'hE7, 4, 32'h3C00_5A00);
        xfer(8'hF0, 4, 32'h0041_0200);
        xfer(8'h32, 2, 32'h1122_0000);
        xfer(8'h70, 2, 32'h3CAA_0000);
        chk(cfg, 8'h3C);
        chk(ths, 8'h22);
        xfer(8'hB2, 2, 32'h2222_0000);
        xfer(8'hB1, 1, 32'h4100_0000);
        xfer(8'h22, 2, 32'h815C_0000);
        chk(ipc, 8'h5C);
        xfer(8'h73, 1, 32'h5C00_0000);
        chk(dur, 8'h5C);
        xfer(8'h20, 1, 32'hF800_0000);
        chk(c1, 8'hF8);
        xfer(8'h20, 1, 32'h0500_0000);
        chk(c1, 8'h05);
        saw = 1'b0;
        xfer(8'h21, 1, 32'h4000_0000);
        chk({7'h00, saw}, 8'h01);
        xfer(8'hA1, 1, 32'h0000_0000);
        xfer(8'h87, 1, 32'h4500_0000);
        xfer(8'h21, 1, 32'h8000_0000);
        chk({7'h00, wm}, 8'h01);
        wr(3'h6, 8'h01);
        xfer(8'hEB, 3, 32'h6600_9900);
        xfer(8'hA1, 1, 32'h8000_0000);
        xfer(8'h21, 1, 32'h0000_0000);
        wr(3'h6, 8'h00);
        // a command offered while frozen must not open a frame
        ce <= 1'b0;
        wr(3'h0, 8'hA0);
        ce <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        chk({6'h00, busy, i_sensor_spi_if.select_n}, 8'h01);
        xfer(8'hA0, 1, 32'h0500_0000);
        wrap_up();
    end
endmodule : tb_sensor_spi_register_port
